// ---- rtl/caf_pkg.sv ----
package caf_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CAF_OFF_FMODE  = 8'h00;
  localparam logic [7:0] CAF_OFF_MASK   = 8'h04;
  localparam logic [7:0] CAF_OFF_CMP    = 8'h08;
  localparam logic [7:0] CAF_OFF_CTRL   = 8'h0C;
  localparam logic [7:0] CAF_OFF_XKIND  = 8'h10;
  localparam logic [7:0] CAF_OFF_XCTL   = 8'h14;
  localparam logic [7:0] CAF_OFF_STATUS = 8'h18;
  localparam logic [7:0] CAF_OFF_STAMP  = 8'h1C;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] CAF_MASK_RST  = 32'hFFFFFFFF;
  localparam logic [31:0] CAF_CMP_RST   = 32'h00000000;
  localparam logic [31:0] CAF_XCTL_RST  = 32'h00000003;
  localparam logic [31:0] CAF_XCTL_USED = 32'h00000103;
  localparam int CAF_XCTL_PIN_A = 0;
  localparam int CAF_XCTL_PIN_B = 1;
  localparam int CAF_XCTL_SLEEP = 8;
  localparam int CAF_CTRL_ONESHOT = 0;
  localparam int CAF_CTRL_CATCHUP = 1;
  localparam int CAF_CTRL_TSMODE  = 2;
  localparam int CAF_CTRL_FMT     = 3;
  localparam int CAF_CTRL_RUN     = 4;
  localparam int CAF_ST_REJECT = 0;
  localparam int CAF_ST_ASLEEP = 1;
  localparam int CAF_ST_SWALOW = 2;
  localparam int CAF_ST_GIVEUP = 3;
  // field splits for dual modes
  localparam int CAF_DSTD_SPLIT = 12;
  localparam int CAF_DEXT_SPLIT = 16;

  // ----------------------------------------------------------------
  // timing: timestamp tick of one microsecond
  // ----------------------------------------------------------------
  localparam int CAF_CLK_NS  = 20;
  localparam int CAF_TICK_NS = 1000;
  localparam int CAF_TICK_CYC = (CAF_TICK_NS + CAF_CLK_NS - 1) / CAF_CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAF_SINGLE_STD,
    CAF_SINGLE_EXT,
    CAF_DUAL_STD,
    CAF_DUAL_EXT
  } caf_fmode_e;

  typedef enum logic [1:0] {
    CAF_KIND_HS,
    CAF_KIND_LS,
    CAF_KIND_SW,
    CAF_KIND_EXT
  } caf_xkind_e;

  localparam logic CAF_TS_TIMESTAMPED = 1'b1;
  localparam logic CAF_FMT_RELATIVE   = 1'b1;

  typedef struct packed {
    logic        ext;
    logic        rtr;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [7:0]  d0;
    logic [7:0]  d1;
  } caf_frame_s;

endpackage

// ---- rtl/caf_top.sv ----
// What this block does
// - filter decides every frame for all receivers
// - single standard: one filter, full 11-bit ID
// - single standard also compares data bytes 0,1
// - RTR field selects remote or data frames
// - single extended: full 29-bit ID plus RTR
// - dual modes: accept if either filter hits
// - dual standard: filter1 ID,RTR,byte0; filter2 ID,RTR
// - dual extended: upper 16 ID bits each
// - mask bit set means don't care
// - mask resets all ones, comparator zero
// - retry failed transmit immediately by default
// - single shot: one attempt, no retry
// - catchup only in timestamped transmit mode
// - no catchup: gap measured from actual send
// - catchup: next frame at original time
// - stamp format absolute zero, relative one
// - format change resets shared timer
// - control bits 0,1 drive mode pins
// - control word resets to three
// - sleep bit sleeps controller, clear wakes
// - remote wakeup restores word to three
// - control word only accepted for external kind
// - wakeup frame neither received nor acknowledged
`timescale 1ns/10ps
`default_nettype none
module caf_top
  import caf_pkg::*;
#(
  parameter int GAP_W = 24
) (
  input  wire logic             clk_i,          // 50 MHz clock
  input  wire logic             sys_rst_i,      // sync reset, active high
  input  wire logic [7:0]       reg_addr_i,     // register byte address
  input  wire logic [31:0]      reg_wdata_i,    // write data
  input  wire logic             reg_wr_i,       // write strobe
  input  wire logic             reg_rd_i,       // read strobe
  output logic      [31:0]      reg_rdata_o,    // read data, cycle after strobe
  input  wire caf_frame_s       rx_frame_i,     // received frame header
  input  wire logic             rx_valid_i,     // frame header valid pulse
  input  wire logic             rx_end_i,       // bus frame ended pulse
  input  wire logic             bus_wake_i,     // bus activity seen pulse
  output caf_frame_s            rx_frame_o,     // accepted frame
  output logic                  rx_accept_o,    // accepted frame pulse
  output logic                  ack_en_o,       // controller may acknowledge
  input  wire logic             tx_pending_i,   // frame waiting to send
  input  wire logic             tx_done_i,      // attempt succeeded pulse
  input  wire logic             tx_fail_i,      // attempt failed pulse
  input  wire logic [GAP_W-1:0] sched_gap_i,    // gap to next frame, ticks
  output logic                  tx_start_o,     // start attempt pulse
  output logic                  tx_drop_o,      // frame abandoned pulse
  output logic                  xcvr_pin_a_o,   // transceiver mode pin a
  output logic                  xcvr_pin_b_o,   // transceiver mode pin b
  output logic                  ctrl_sleep_o,   // controller asleep
  output logic      [31:0]      stamp_o,        // current timestamp
  output logic                  timer_clr_o,    // shared timer clear to peer
  input  wire logic             peer_clr_i      // shared timer clear from peer
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  caf_fmode_e  accept_filter_mode;
  logic [31:0] accept_mask_r;
  logic [31:0] accept_compare_r;
  logic        one_attempt_tx;
  logic        schedule_catchup;
  logic        tx_schedule_kind;
  logic        stamp_format;
  logic        comm_run_r;
  caf_xkind_e  xcvr_kind_select;
  logic [31:0] ext_xcvr_ctl_word;
  logic        reject_r;
  logic        giveup_r;
  logic        swallow_r;
  logic [31:0] timer_r;
  logic [31:0] base_r;
  logic [31:0] stamp_nxt;
  logic [31:0] due_r;
  logic [7:0]  tick_cnt_r;
  logic        tick_r;

  logic wr_fmode, wr_mask, wr_cmp, wr_ctrl, wr_xkind, wr_xctl, wr_stat;
  logic fmt_change;
  logic asleep;

  assign wr_fmode = reg_wr_i && reg_addr_i == CAF_OFF_FMODE;
  assign wr_mask  = reg_wr_i && reg_addr_i == CAF_OFF_MASK;
  assign wr_cmp   = reg_wr_i && reg_addr_i == CAF_OFF_CMP;
  assign wr_ctrl  = reg_wr_i && reg_addr_i == CAF_OFF_CTRL;
  assign wr_xkind = reg_wr_i && reg_addr_i == CAF_OFF_XKIND;
  assign wr_xctl  = reg_wr_i && reg_addr_i == CAF_OFF_XCTL;
  assign wr_stat  = reg_wr_i && reg_addr_i == CAF_OFF_STATUS;
  assign asleep   = ext_xcvr_ctl_word[CAF_XCTL_SLEEP];
  assign fmt_change = wr_ctrl && (reg_wdata_i[CAF_CTRL_FMT] != stamp_format);

  // reconfiguration is trusted to happen while stopped; writes are not gated
  // filter reset values
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      accept_filter_mode <= CAF_SINGLE_STD;
      accept_mask_r      <= CAF_MASK_RST;
      accept_compare_r   <= CAF_CMP_RST;
    end else begin
      if (wr_fmode) begin
        accept_filter_mode <= caf_fmode_e'(reg_wdata_i[1:0]);
      end
      if (wr_mask) begin
        accept_mask_r <= reg_wdata_i;
      end
      if (wr_cmp) begin
        accept_compare_r <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      one_attempt_tx   <= 1'b0;
      schedule_catchup <= 1'b0;
      tx_schedule_kind <= 1'b0;
      stamp_format     <= 1'b0;
      comm_run_r       <= 1'b0;
      xcvr_kind_select <= CAF_KIND_HS;
    end else begin
      if (wr_ctrl) begin
        one_attempt_tx   <= reg_wdata_i[CAF_CTRL_ONESHOT];
        schedule_catchup <= reg_wdata_i[CAF_CTRL_CATCHUP];
        tx_schedule_kind <= reg_wdata_i[CAF_CTRL_TSMODE];
        stamp_format     <= reg_wdata_i[CAF_CTRL_FMT];
        comm_run_r       <= reg_wdata_i[CAF_CTRL_RUN];
      end
      if (wr_xkind) begin
        xcvr_kind_select <= caf_xkind_e'(reg_wdata_i[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // external transceiver control and wakeup
  // ----------------------------------------------------------------
  // control word
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_xcvr_ctl_word <= CAF_XCTL_RST;
    end else if (asleep && bus_wake_i) begin
      ext_xcvr_ctl_word <= CAF_XCTL_RST;
    end else if (wr_xctl && xcvr_kind_select == CAF_KIND_EXT) begin
      ext_xcvr_ctl_word <= reg_wdata_i & CAF_XCTL_USED;
    end
  end

  // rejected write flag, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reject_r <= 1'b0;
    end else if (wr_xctl && xcvr_kind_select != CAF_KIND_EXT) begin
      reject_r <= 1'b1;
    end else if (wr_stat && reg_wdata_i[CAF_ST_REJECT]) begin
      reject_r <= 1'b0;
    end
  end

  // wakeup frame is swallowed until it ends
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      swallow_r <= 1'b0;
    end else if (asleep && bus_wake_i) begin
      swallow_r <= 1'b1;
    end else if (rx_end_i) begin
      swallow_r <= 1'b0;
    end
  end

  // mode pins follow bits 0 and 1
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      xcvr_pin_a_o <= CAF_XCTL_RST[CAF_XCTL_PIN_A];
      xcvr_pin_b_o <= CAF_XCTL_RST[CAF_XCTL_PIN_B];
      ctrl_sleep_o <= CAF_XCTL_RST[CAF_XCTL_SLEEP];
      ack_en_o     <= 1'b1;
    end else begin
      xcvr_pin_a_o <= ext_xcvr_ctl_word[CAF_XCTL_PIN_A];
      xcvr_pin_b_o <= ext_xcvr_ctl_word[CAF_XCTL_PIN_B];
      ctrl_sleep_o <= asleep;
      ack_en_o     <= !asleep && !swallow_r && !(asleep && bus_wake_i);
    end
  end

  // ----------------------------------------------------------------
  // acceptance filter
  // ----------------------------------------------------------------
  logic [31:0] probe;
  logic [31:0] eq;
  logic        hit;

  // field layout per mode, same for mask and comparator
  // reserved probe bits are zero so a zero comparator matches
  always_comb begin
    probe = 32'h00000000;
    unique case (accept_filter_mode)
      CAF_SINGLE_STD: probe = {rx_frame_i.id[10:0], rx_frame_i.rtr, 4'h0,
                               rx_frame_i.d0, rx_frame_i.d1};
      CAF_SINGLE_EXT: probe = {rx_frame_i.id, rx_frame_i.rtr, 2'h0};
      CAF_DUAL_STD:   probe = {rx_frame_i.id[10:0], rx_frame_i.rtr, rx_frame_i.d0,
                               rx_frame_i.id[10:0], rx_frame_i.rtr};
      CAF_DUAL_EXT:   probe = {rx_frame_i.id[28:13], rx_frame_i.id[28:13]};
    endcase
  end

  // set mask bit forces a match
  // rtr compared like any other bit
  assign eq = accept_mask_r | ~(probe ^ accept_compare_r);

  always_comb begin
    hit = 1'b0;
    unique case (accept_filter_mode)
      CAF_SINGLE_STD: hit = !rx_frame_i.ext && (&eq);
      CAF_SINGLE_EXT: hit = rx_frame_i.ext && (&eq);
      CAF_DUAL_STD:   hit = !rx_frame_i.ext && ((&eq[31:CAF_DSTD_SPLIT]) ||
                                                (&eq[CAF_DSTD_SPLIT-1:0]));
      CAF_DUAL_EXT:   hit = rx_frame_i.ext && ((&eq[31:CAF_DEXT_SPLIT]) ||
                                               (&eq[CAF_DEXT_SPLIT-1:0]));
    endcase
  end

  // one decision feeds every downstream receiver
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_accept_o <= 1'b0;
      rx_frame_o  <= '0;
    end else begin
      rx_accept_o <= rx_valid_i && hit && comm_run_r && !asleep && !swallow_r
                     && !bus_wake_i;
      if (rx_valid_i) begin
        rx_frame_o <= rx_frame_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared timer and timestamp
  // ----------------------------------------------------------------
  // tick divider; a long tick keeps the 32-bit stamp from wrapping soon
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || fmt_change || peer_clr_i) begin
      tick_cnt_r <= 8'h00;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 8'(CAF_TICK_CYC - 1)) begin
      tick_cnt_r <= 8'h00;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
      tick_r     <= 1'b0;
    end
  end

  // format change clears the timer here and at the peer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || fmt_change || peer_clr_i) begin
      timer_r <= 32'h00000000;
    end else if (tick_r) begin
      timer_r <= timer_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_clr_o <= 1'b0;
    end else begin
      timer_clr_o <= fmt_change;
    end
  end

  // relative base is caught when communication starts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || fmt_change || peer_clr_i) begin
      base_r <= 32'h00000000;
    end else if (wr_ctrl && reg_wdata_i[CAF_CTRL_RUN] && !comm_run_r) begin
      base_r <= timer_r;
    end
  end

  assign stamp_nxt = (stamp_format == CAF_FMT_RELATIVE) ? timer_r - base_r : timer_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stamp_o <= 32'h00000000;
    end else begin
      stamp_o <= stamp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit attempts and schedule
  // ----------------------------------------------------------------
  typedef enum logic {CAF_TX_IDLE, CAF_TX_BUSY} caf_txst_e;
  caf_txst_e tx_st;
  logic      due_ok;
  logic      go;

  // the schedule only holds frames in timestamped mode
  assign due_ok = (tx_schedule_kind != CAF_TS_TIMESTAMPED) || (timer_r >= due_r);
  assign go     = tx_pending_i && comm_run_r && !asleep && due_ok;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_st      <= CAF_TX_IDLE;
      tx_start_o <= 1'b0;
      tx_drop_o  <= 1'b0;
    end else begin
      tx_start_o <= 1'b0;
      tx_drop_o  <= 1'b0;
      unique case (tx_st)
        CAF_TX_IDLE: begin
          if (go) begin
            tx_start_o <= 1'b1;
            tx_st      <= CAF_TX_BUSY;
          end
        end
        CAF_TX_BUSY: begin
          if (tx_done_i) begin
            tx_st <= CAF_TX_IDLE;
          end else if (tx_fail_i) begin
            if (one_attempt_tx) begin
              tx_drop_o <= 1'b1;
              tx_st     <= CAF_TX_IDLE;
            end else begin
              tx_start_o <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      giveup_r <= 1'b0;
    end else if (tx_st == CAF_TX_BUSY && tx_fail_i && one_attempt_tx) begin
      giveup_r <= 1'b1;
    end else if (wr_stat && reg_wdata_i[CAF_ST_GIVEUP]) begin
      giveup_r <= 1'b0;
    end
  end

  // due time of the next scheduled frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      due_r <= 32'h00000000;
    end else if (wr_ctrl && reg_wdata_i[CAF_CTRL_RUN] && !comm_run_r) begin
      due_r <= timer_r;
    end else if (tx_st == CAF_TX_BUSY && tx_done_i) begin
      if (schedule_catchup) begin
        due_r <= due_r + 32'(sched_gap_i);
      end else begin
        // gap counts from the actual send
        due_r <= timer_r + 32'(sched_gap_i);
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        CAF_OFF_FMODE:  reg_rdata_o <= {30'h0, accept_filter_mode};
        CAF_OFF_MASK:   reg_rdata_o <= accept_mask_r;
        CAF_OFF_CMP:    reg_rdata_o <= accept_compare_r;
        CAF_OFF_CTRL:   reg_rdata_o <= {27'h0, comm_run_r, stamp_format,
                                        tx_schedule_kind, schedule_catchup,
                                        one_attempt_tx};
        CAF_OFF_XKIND:  reg_rdata_o <= {30'h0, xcvr_kind_select};
        CAF_OFF_XCTL:   reg_rdata_o <= ext_xcvr_ctl_word;
        CAF_OFF_STATUS: reg_rdata_o <= {28'h0, giveup_r, swallow_r, asleep, reject_r};
        CAF_OFF_STAMP:  reg_rdata_o <= stamp_nxt;
        default:        reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_filter_reset: assert property (@(posedge clk_i)
    $fell(sys_rst_i) |-> accept_mask_r == CAF_MASK_RST && accept_compare_r == CAF_CMP_RST)
    else $error("filter not at reset values");

  a_sleep_withhold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_accept_o |-> !$past(asleep) && !$past(swallow_r))
    else $error("frame accepted while asleep or swallowing");

  a_dual_either: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_valid_i && comm_run_r && !asleep && !swallow_r && !bus_wake_i && !rx_frame_i.ext
    && accept_filter_mode == CAF_DUAL_STD
    && (&eq[CAF_DSTD_SPLIT-1:0]) |=> rx_accept_o)
    else $error("dual filter hit not accepted");

  a_retry_now: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_st == CAF_TX_BUSY && tx_fail_i && !tx_done_i && !one_attempt_tx
    |=> tx_start_o && tx_st == CAF_TX_BUSY)
    else $error("failed frame not retried at once");

  a_one_attempt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_st == CAF_TX_BUSY && tx_fail_i && !tx_done_i && one_attempt_tx
    |=> tx_drop_o && !tx_start_o ##1 !tx_start_o)
    else $error("single shot frame retried");

  a_wake_restore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    asleep && bus_wake_i |=> ext_xcvr_ctl_word == CAF_XCTL_RST ##1 xcvr_pin_a_o
    && xcvr_pin_b_o && !ctrl_sleep_o)
    else $error("remote wakeup did not restore control word");

  a_xctl_refuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_xctl && xcvr_kind_select != CAF_KIND_EXT && !(asleep && bus_wake_i)
    |=> $stable(ext_xcvr_ctl_word) && reject_r)
    else $error("control word taken for internal transceiver");

  a_pin_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_xctl && xcvr_kind_select == CAF_KIND_EXT && !(asleep && bus_wake_i)
    |=> ##1 xcvr_pin_a_o == $past(reg_wdata_i[CAF_XCTL_PIN_A], 2)
    && xcvr_pin_b_o == $past(reg_wdata_i[CAF_XCTL_PIN_B], 2))
    else $error("mode pins do not follow control word");

  a_fmt_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fmt_change |=> timer_r == 32'h00000000 && timer_clr_o)
    else $error("format change did not clear timer");

  a_catchup_due: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_st == CAF_TX_BUSY && tx_done_i && schedule_catchup && !wr_ctrl
    |=> due_r == $past(due_r) + 32'($past(sched_gap_i)))
    else $error("catchup due time not on original timeline");

endmodule
`default_nettype wire

// ---- verification/caf_node_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module caf_node_model (
  input  wire logic clk_i,      // bus clock
  input  wire logic start_i,    // attempt started
  input  wire logic fail_all_i, // every attempt goes unacknowledged
  output logic      done_o,     // attempt acknowledged
  output logic      fail_o      // attempt lost
);
  logic wait_r;

  initial begin
    done_o = 1'b0;
    fail_o = 1'b0;
    wait_r = 1'b0;
  end

  always @(posedge clk_i) begin
    done_o <= 1'b0;
    fail_o <= 1'b0;
    wait_r <= start_i;
    if (wait_r) begin
      done_o <= !fail_all_i;
      fail_o <= fail_all_i;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import caf_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, fail_all = 1'b0;
  logic rx_valid_i = 1'b0, rx_end_i = 1'b0, bus_wake_i = 1'b0, tx_pending_i = 1'b0;
  logic tx_done_i, tx_fail_i, tx_start_o, tx_drop_o, rx_accept_o, ack_en_o, timer_clr_o;
  logic xcvr_pin_a_o, xcvr_pin_b_o, ctrl_sleep_o, rd_seen = 1'b0, oneshot = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, stamp_o, rd_q[$];
  logic [15:0] u;
  caf_frame_s rx_frame_i = '0, rx_frame_o, f, g, exp_q[$];
  int miscompares = 0, compares = 0, starts = 0;

  always #10 clk_i = ~clk_i;

  caf_top #(.GAP_W(24)) i_caf_top (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .rx_frame_i, .rx_valid_i, .rx_end_i, .bus_wake_i, .rx_frame_o,
    .rx_accept_o, .ack_en_o, .tx_pending_i, .tx_done_i, .tx_fail_i, .sched_gap_i(24'h000010),
    .tx_start_o, .tx_drop_o, .xcvr_pin_a_o, .xcvr_pin_b_o, .ctrl_sleep_o, .stamp_o,
    .timer_clr_o, .peer_clr_i(1'b0));
  caf_node_model i_caf_node_model (.clk_i, .start_i(tx_start_o), .fail_all_i(fail_all),
    .done_o(tx_done_i), .fail_o(tx_fail_i));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // result watcher: oldest note against what appears
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rd_seen) chk(reg_rdata_o, rd_q.size() ? rd_q.pop_front() : '1, "read data");
    rd_seen = reg_rd_i;
    if (rx_accept_o) chk(rx_frame_o, exp_q.size() ? exp_q.pop_front() : '1, "frame");
    if (tx_start_o) starts++;
    // a single-shot failure ends the frame, so pending must be low before the drop edge
    if (tx_done_i || tx_drop_o || (tx_fail_i && oneshot)) tx_pending_i <= 1'b0;
  end

  // one register cycle; reads note the expected word
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    if (!w) rd_q.push_back(d);
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask

  task automatic frm(input caf_frame_s fr, input logic ok);
    @(posedge clk_i);
    rx_frame_i <= fr;
    rx_valid_i <= 1'b1;
    if (ok) exp_q.push_back(fr);
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
  endtask

  task automatic pulse(input logic w);
    @(posedge clk_i);
    bus_wake_i <= w;
    rx_end_i <= !w;
    @(posedge clk_i);
    bus_wake_i <= 1'b0;
    rx_end_i <= 1'b0;
  endtask

  // stop, write zeroed reserved bits, restart
  task automatic cfg(input logic [1:0] m, input logic [31:0] mk, input logic [31:0] cp);
    acc(1'b1, CAF_OFF_CTRL, 32'h0);
    acc(1'b1, CAF_OFF_FMODE, {30'h0, m});
    acc(1'b1, CAF_OFF_MASK, mk);
    acc(1'b1, CAF_OFF_CMP, cp);
    acc(1'b1, CAF_OFF_CTRL, 32'h10);
  endtask

  task automatic wait_on(input int k);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_i);
      if ((k == 0 && tx_done_i) || (k == 1 && tx_drop_o) || (k == 2 && timer_clr_o)) return;
      if (k == 3 && starts >= 3) return;
    end
    miscompares++;
    finish_test();
  endtask

  initial begin
    void'($urandom(29587));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    acc(1'b0, CAF_OFF_MASK, CAF_MASK_RST);
    acc(1'b0, CAF_OFF_CMP, CAF_CMP_RST);
    acc(1'b0, CAF_OFF_XCTL, CAF_XCTL_RST);
    acc(1'b0, 8'h20, 32'h0);
    chk({xcvr_pin_a_o, xcvr_pin_b_o, ctrl_sleep_o}, 3'b110, "pins");
    f = caf_frame_s'($bits(caf_frame_s)'({$urandom(), $urandom()}));
    f.ext = 1'b0;
    f.id[28:11] = 18'h0;
    cfg(2'd0, 32'h0, {f.id[10:0], f.rtr, 4'h0, f.d0, f.d1});
    frm(f, 1'b1);
    g = f;
    g.d1[0] = !g.d1[0];
    frm(g, 1'b0);
    g.d1 = f.d1;
    g.rtr = !f.rtr;
    frm(g, 1'b0);
    cfg(2'd0, 32'h00000001, {f.id[10:0], f.rtr, 4'h0, f.d0, f.d1});
    g = f;
    g.d1[0] = !g.d1[0];
    frm(g, 1'b1);
    cfg(2'd2, 32'h0, {f.id[10:0], f.rtr, f.d0, ~f.id[10:0], !f.rtr});
    frm(f, 1'b1);
    g = f;
    g.d0 = ~f.d0;
    frm(g, 1'b0);
    cfg(2'd2, 32'h0, {~f.id[10:0], f.rtr, f.d0, f.id[10:0], f.rtr});
    frm(g, 1'b1);
    f.ext = 1'b1;
    f.id = 29'($urandom());
    cfg(2'd1, 32'h0, {f.id, f.rtr, 2'b00});
    frm(f, 1'b1);
    g = f;
    g.id[0] = !g.id[0];
    frm(g, 1'b0);
    g = f;
    g.ext = 1'b0;
    frm(g, 1'b0);
    u = f.id[28:13];
    for (int s = 0; s < 2; s++) begin
      cfg(2'd3, 32'h0, s ? {~u, u} : {u, ~u});
      g = f;
      g.id[12:0] = ~g.id[12:0];
      frm(g, 1'b1);
      g.id[28] = !g.id[28];
      frm(g, 1'b0);
    end
    acc(1'b1, CAF_OFF_XCTL, 32'h0);
    acc(1'b0, CAF_OFF_XCTL, 32'h00000003);
    acc(1'b1, CAF_OFF_XKIND, 32'h00000003);
    acc(1'b1, CAF_OFF_XCTL, 32'h00000101);
    acc(1'b0, CAF_OFF_XCTL, 32'h00000101);
    chk({xcvr_pin_a_o, xcvr_pin_b_o, ctrl_sleep_o}, 3'b101, "pins");
    frm(f, 1'b0);
    pulse(1'b1);
    frm(f, 1'b0);
    pulse(1'b0);
    acc(1'b0, CAF_OFF_XCTL, 32'h00000003);
    chk({xcvr_pin_a_o, xcvr_pin_b_o, ctrl_sleep_o, ack_en_o}, 4'b1101, "awake");
    frm(f, 1'b1);
    fail_all <= 1'b1;
    tx_pending_i <= 1'b1;
    wait_on(3);
    fail_all <= 1'b0;
    wait_on(0);
    acc(1'b1, CAF_OFF_CTRL, 32'h0);
    acc(1'b1, CAF_OFF_CTRL, 32'h00000011);
    fail_all <= 1'b1;
    starts = 0;
    oneshot <= 1'b1;
    tx_pending_i <= 1'b1;
    wait_on(1);
    repeat (4) @(posedge clk_i);
    chk(starts, 1, "attempts");
    acc(1'b1, CAF_OFF_CTRL, 32'h00000018);
    wait_on(2);
    acc(1'b0, CAF_OFF_STAMP, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(exp_q.size() + rd_q.size(), 0, "pending notes");
    finish_test();
  end
endmodule
`default_nettype wire
